// [verilog/isre_sequencer.sv]
// Sequence counter and register effects of the order classes
// Behaviour
// - Input transfers leave word in Q and buffer
// - Output transfers leave last word in buffer
// - Q aux holds Q shifted right, sign kept, after input transfer, divide, left shift
// - Accumulator aux shifted accumulator image, except after sync print
// - Tape load sums all words into accumulator
// - Summing drum input sums fifty words
// - Add, multiply, right shift: aux left
// - Divide, left shift: aux right
// - Sync print sets accumulator all ones
// - Counter holds next fetch address
// - Operator may set counter before starting
// - Counter steps after fetch unless transfer
// - Taken transfer loads counter from address field
// - Load stores words at consecutive addresses
// - Load end restores initial counter address
// - Drum order walks fifty addresses
// - Drum order ends at bigits 28-39
// - Holding register zero during load
// - Bad order halts, counter minus one locates
`timescale 1ns/1ps
`default_nettype none
module isre_sequencer
	import isre_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic nrst_i, // Sync reset, low
	input wire isre_console_s console_i, // Operator pins
	input wire logic fetch_i, // Fetched word valid
	input wire logic [WORD_W-1:0] fetch_word_i, // Fetched word
	input wire logic exec_i, // Order completes
	input wire isre_exec_s exec_data_i, // Order results
	input wire logic xfer_valid_i, // Tape or drum word
	input wire logic [WORD_W-1:0] xfer_word_i, // Transfer word
	input wire logic xfer_end_i, // Tape block end
	output logic [ADDR_W-1:0] seq_counter_o, // Next address
	output isre_regs_s regs_o, // Register contents
	output isre_mem_wr_s mem_wr_o, // Memory write
	output logic fetch_req_o, // Wants a fetch
	output logic exec_req_o, // Order in holding reg
	output logic xfer_busy_o, // Load or transfer on
	output logic running_o, // Automatic running
	output logic halt_o // Bad order stop
);
	isre_state_e state_q, state_d;
	isre_regs_s regs_q, regs_d;
	isre_mem_wr_s mwr_q, mwr_d;
	logic [ADDR_W-1:0] seq_q, seq_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [ADDR_W-1:0] fetch_addr_q, fetch_addr_d;
	logic [5:0] cnt_q, cnt_d;
	logic have_q, have_d;
	logic xin_q, xin_d;
	logic xdrum_q, xdrum_d;
	logic xsum_q, xsum_d;
	isre_console_s con_s1, con_s2, con_s3;
	isre_console_s con_f, con_f_d, con_p;
	logic start_e, stop_e, load_e, set_e;
	isre_class_e cls;
	logic exec_go, word_go;
	logic [ADDR_W-1:0] mem_field;
	logic acc_upd, acc_left, q_upd, q_left;
	logic [WORD_W-1:0] acc_new, q_new, acc_sh, q_sh;

	// Console pins: three flops, change taken when two and three agree
	always_comb begin
		con_f_d = (~(con_s2 ^ con_s3) & con_s3) | ((con_s2 ^ con_s3) & con_f);
	end
	assign start_e = con_f.start & ~con_p.start;
	assign stop_e = con_f.stop & ~con_p.stop;
	assign load_e = con_f.load & ~con_p.load;
	assign set_e = con_f.set & ~con_p.set;

	// Order decode and event qualifiers
	assign cls = op_class(regs_q.instruction_holding_register[OP_LSB+:OP_W]);
	assign exec_go = (state_q == ST_RUN) && have_q && exec_i && (cls != CL_BAD) && !stop_e;
	assign word_go = xfer_valid_i && ((state_q == ST_LOAD) || (state_q == ST_XFER));
	assign mem_field = regs_q.instruction_holding_register[MEM_LSB+:ADDR_W];

	// New accumulator and quotient words, with shift direction
	always_comb begin
		acc_upd = 1'b0;
		acc_new = regs_q.accumulator_register;
		acc_left = 1'b1;
		q_upd = 1'b0;
		q_new = regs_q.quotient_register;
		q_left = 1'b1;
		if (exec_go) begin
			case (cls)
				CL_ADD: begin
					acc_upd = 1'b1;
					acc_new = exec_data_i.acc_res;
				end
				CL_MUL, CL_SHR: begin
					acc_upd = 1'b1;
					acc_new = exec_data_i.acc_res;
					q_upd = 1'b1;
					q_new = exec_data_i.q_res;
				end
				CL_DIV, CL_SHL: begin
					acc_upd = 1'b1;
					acc_new = exec_data_i.acc_res;
					acc_left = 1'b0;
					q_upd = 1'b1;
					q_new = exec_data_i.q_res;
					q_left = 1'b0;
				end
				default: begin
					acc_upd = 1'b0;
				end
			endcase
		end else if (word_go) begin
			if ((state_q == ST_LOAD) || xsum_q) begin
				acc_upd = 1'b1;
				acc_new = WORD_W'(regs_q.accumulator_register + xfer_word_i);
			end
			if ((state_q == ST_XFER) && xin_q) begin
				q_upd = 1'b1;
				q_new = xfer_word_i;
				q_left = 1'b0;
			end
		end
	end

	// Auxiliary images of the new words
	isre_aux_shift u_acc_shift (
		.word_i(acc_new),
		.left_i(acc_left),
		.aux_o(acc_sh)
	);
	isre_aux_shift u_q_shift (
		.word_i(q_new),
		.left_i(q_left),
		.aux_o(q_sh)
	);

	// Next state of the sequencer and registers
	always_comb begin
		state_d = state_q;
		regs_d = regs_q;
		mwr_d = mwr_q;
		mwr_d.valid = 1'b0;
		seq_d = seq_q;
		base_d = base_q;
		fetch_addr_d = fetch_addr_q;
		cnt_d = cnt_q;
		have_d = have_q;
		xin_d = xin_q;
		xdrum_d = xdrum_q;
		xsum_d = xsum_q;
		if (acc_upd) begin
			regs_d.accumulator_register = acc_new;
			regs_d.accumulator_aux_register = acc_sh;
		end
		if (q_upd) begin
			regs_d.quotient_register = q_new;
			regs_d.quotient_aux_register = q_sh;
		end
		case (state_q)
			ST_STOP: begin
				if (set_e) begin
					seq_d = con_f.addr;
				end else if (load_e) begin
					base_d = seq_q;
					// Checksum starts from zero
					regs_d.accumulator_register = WORD_ZERO;
					regs_d.accumulator_aux_register = WORD_ZERO;
					regs_d.instruction_holding_register = WORD_ZERO;
					state_d = ST_LOAD;
				end else if (start_e) begin
					have_d = 1'b0;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop_e) begin
					state_d = ST_STOP;
				end else if (have_q && (cls == CL_BAD)) begin
					state_d = ST_HALT;
				end else if (!have_q && fetch_i) begin
					regs_d.instruction_holding_register = fetch_word_i;
					fetch_addr_d = seq_q;
					seq_d = seq_q + ADDR_ONE;
					have_d = 1'b1;
				end else if (exec_go) begin
					have_d = 1'b0;
					case (cls)
						CL_ADD, CL_MUL, CL_DIV: begin
							regs_d.memory_transfer_buffer = exec_data_i.operand;
						end
						CL_MQ: begin
							regs_d.memory_transfer_buffer = exec_data_i.operand;
							regs_d.quotient_register = exec_data_i.operand;
						end
						CL_STORE: begin
							mwr_d.valid = 1'b1;
							mwr_d.addr = regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W];
							mwr_d.data = regs_q.accumulator_register;
						end
						CL_JUMP: begin
							seq_d = regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W];
						end
						CL_JCOND: begin
							if (exec_data_i.cond_met) begin
								seq_d = regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W];
							end
						end
						CL_SYNC: begin
							regs_d.accumulator_register = WORD_ONES;
						end
						CL_TAPE_IN, CL_TAPE_OUT: begin
							xin_d = (cls == CL_TAPE_IN);
							xdrum_d = 1'b0;
							xsum_d = 1'b0;
							state_d = ST_XFER;
						end
						CL_DRUM_IN, CL_DRUM_OUT: begin
							xin_d = (cls == CL_DRUM_IN);
							xdrum_d = 1'b1;
							cnt_d = 6'h00;
							xsum_d = (cls == CL_DRUM_IN) && (mem_field >= DRUM_SUM_OFS);
							if (xsum_d) begin
								seq_d = mem_field - DRUM_SUM_OFS;
								regs_d.accumulator_register = WORD_ZERO;
								regs_d.accumulator_aux_register = WORD_ZERO;
							end else begin
								seq_d = mem_field;
							end
							state_d = ST_XFER;
						end
						default: begin
							have_d = 1'b0;
						end
					endcase
				end
			end
			ST_LOAD: begin
				regs_d.instruction_holding_register = WORD_ZERO;
				if (xfer_valid_i) begin
					mwr_d.valid = 1'b1;
					mwr_d.addr = seq_q;
					mwr_d.data = xfer_word_i;
					regs_d.memory_transfer_buffer = xfer_word_i;
					seq_d = seq_q + ADDR_ONE;
				end else if (xfer_end_i) begin
					seq_d = base_q;
					state_d = ST_STOP;
				end
			end
			ST_XFER: begin
				if (xfer_valid_i) begin
					regs_d.memory_transfer_buffer = xfer_word_i;
					if (xin_q) begin
						mwr_d.valid = 1'b1;
						mwr_d.addr = seq_q;
						mwr_d.data = xfer_word_i;
					end
					if (xdrum_q) begin
						if (cnt_q == DRUM_LAST) begin
							seq_d = regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W];
							state_d = ST_RUN;
						end else begin
							seq_d = seq_q + ADDR_ONE;
							cnt_d = cnt_q + CNT_ONE;
						end
					end
				end else if (xfer_end_i && !xdrum_q) begin
					state_d = ST_RUN;
				end
			end
			ST_HALT: begin
				if (stop_e) begin
					state_d = ST_STOP;
				end
			end
			default: begin
				state_d = ST_STOP;
			end
		endcase
	end

	// Register update, synchronous reset
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state_q <= ST_STOP;
			regs_q <= '0;
			mwr_q <= '0;
			seq_q <= ADDR_RST;
			base_q <= ADDR_RST;
			fetch_addr_q <= ADDR_RST;
			cnt_q <= 6'h00;
			have_q <= 1'b0;
			xin_q <= 1'b0;
			xdrum_q <= 1'b0;
			xsum_q <= 1'b0;
			con_s1 <= '0;
			con_s2 <= '0;
			con_s3 <= '0;
			con_f <= '0;
			con_p <= '0;
		end else begin
			state_q <= state_d;
			regs_q <= regs_d;
			mwr_q <= mwr_d;
			seq_q <= seq_d;
			base_q <= base_d;
			fetch_addr_q <= fetch_addr_d;
			cnt_q <= cnt_d;
			have_q <= have_d;
			xin_q <= xin_d;
			xdrum_q <= xdrum_d;
			xsum_q <= xsum_d;
			con_s1 <= console_i;
			con_s2 <= con_s1;
			con_s3 <= con_s2;
			con_f <= con_f_d;
			con_p <= con_f;
		end
	end

	// Outputs
	assign seq_counter_o = seq_q;
	assign regs_o = regs_q;
	assign mem_wr_o = mwr_q;
	assign fetch_req_o = (state_q == ST_RUN) && !have_q;
	assign exec_req_o = (state_q == ST_RUN) && have_q;
	assign xfer_busy_o = (state_q == ST_LOAD) || (state_q == ST_XFER);
	assign running_o = (state_q == ST_RUN);
	assign halt_o = (state_q == ST_HALT);

	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	fetch_step_a: assert property (
		(state_q == ST_RUN) && !have_q && fetch_i && !stop_e
		|=> seq_q == ADDR_W'($past(seq_q) + 1) && fetch_addr_q == $past(seq_q))
		else $error("counter did not step on fetch");
	jump_load_a: assert property (
		exec_go && ((cls == CL_JUMP) || ((cls == CL_JCOND) && exec_data_i.cond_met))
		|=> seq_q == $past(regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W]))
		else $error("transfer did not load counter");
	xfer_in_a: assert property (
		(state_q == ST_XFER) && xin_q && xfer_valid_i
		|=> regs_q.quotient_register == $past(xfer_word_i)
			&& regs_q.memory_transfer_buffer == regs_q.quotient_register)
		else $error("input transfer word not in Q and buffer");
	xfer_out_a: assert property (
		(state_q == ST_XFER) && !xin_q && xfer_valid_i
		|=> regs_q.memory_transfer_buffer == $past(xfer_word_i))
		else $error("output transfer word not in buffer");
	q_aux_a: assert property (
		(state_q == ST_XFER) && xin_q && xfer_valid_i
		|=> regs_q.quotient_aux_register
			== {regs_q.quotient_register[WORD_W-1], regs_q.quotient_register[WORD_W-1:1]})
		else $error("Q aux not right image");
	load_sum_a: assert property (
		(state_q == ST_LOAD) && xfer_valid_i
		|=> regs_q.accumulator_register
			== WORD_W'($past(regs_q.accumulator_register) + $past(xfer_word_i))
			&& mem_wr_o.valid && mem_wr_o.addr == $past(seq_q))
		else $error("load word not summed or stored");
	add_aux_a: assert property (
		exec_go && (cls == CL_ADD) |=> regs_q.accumulator_aux_register
			== {regs_q.accumulator_register[WORD_W-1], regs_q.accumulator_register[WORD_W-3:0], 1'b0})
		else $error("acc aux not left image");
	div_aux_a: assert property (
		exec_go && ((cls == CL_DIV) || (cls == CL_SHL)) |=> regs_q.accumulator_aux_register
			== {regs_q.accumulator_register[WORD_W-1], regs_q.accumulator_register[WORD_W-1:1]})
		else $error("acc aux not right image");
	sync_ones_a: assert property (
		exec_go && (cls == CL_SYNC) |=> regs_q.accumulator_register == WORD_ONES)
		else $error("sync print left acc not all ones");
	load_ret_a: assert property (
		(state_q == ST_LOAD) && !xfer_valid_i && xfer_end_i
		|=> seq_q == $past(base_q) && state_q == ST_STOP)
		else $error("load end did not restore counter");
	load_zero_a: assert property (
		(state_q == ST_LOAD) |=> regs_q.instruction_holding_register == WORD_ZERO)
		else $error("holding register not zero in load");
	drum_end_a: assert property (
		(state_q == ST_XFER) && xdrum_q && xfer_valid_i && (cnt_q == DRUM_LAST)
		|=> seq_q == $past(regs_q.instruction_holding_register[ADDR_LSB+:ADDR_W]) && running_o)
		else $error("drum end address wrong");
	halt_loc_a: assert property (
		halt_o |-> seq_q == ADDR_W'(fetch_addr_q + 1))
		else $error("halt counter does not locate order");
endmodule
`default_nettype wire

// [verilog/isre_pkg.sv]
// Package: word layout, order codes, states and carriers of the sequencer
package isre_pkg;
	localparam int WORD_W = 40;
	localparam int ADDR_W = 12;
	localparam int OP_W = 8;
	// Field positions; vector bit 39 is the sign bigit
	localparam int ADDR_LSB = 0;
	localparam int OP_LSB = 12;
	localparam int MEM_LSB = 20;
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
	localparam logic [ADDR_W-1:0] DRUM_SUM_OFS = 12'h320;
	localparam logic [5:0] DRUM_LAST = 6'h31;
	localparam logic [5:0] CNT_ONE = 6'h01;
	localparam logic [WORD_W-1:0] WORD_ZERO = 40'h00_0000_0000;
	localparam logic [WORD_W-1:0] WORD_ONES = 40'hff_ffff_ffff;
	// Order codes
	localparam logic [OP_W-1:0] OP_ADD = 8'h01;
	localparam logic [OP_W-1:0] OP_ABS_ADD = 8'h02;
	localparam logic [OP_W-1:0] OP_MUL = 8'h03;
	localparam logic [OP_W-1:0] OP_DIV = 8'h04;
	localparam logic [OP_W-1:0] OP_SHR = 8'h05;
	localparam logic [OP_W-1:0] OP_SHL = 8'h06;
	localparam logic [OP_W-1:0] OP_MEM_TO_Q = 8'h07;
	localparam logic [OP_W-1:0] OP_STORE = 8'h08;
	localparam logic [OP_W-1:0] OP_JUMP = 8'h09;
	localparam logic [OP_W-1:0] OP_JUMP_COND = 8'h0a;
	localparam logic [OP_W-1:0] OP_TAPE_IN = 8'h0b;
	localparam logic [OP_W-1:0] OP_TAPE_OUT = 8'h0c;
	localparam logic [OP_W-1:0] OP_DRUM_IN = 8'h0d;
	localparam logic [OP_W-1:0] OP_DRUM_OUT = 8'h0e;
	localparam logic [OP_W-1:0] OP_SYNC_PRINT = 8'h0f;

	typedef enum logic [3:0] {
		CL_BAD, CL_ADD, CL_MUL, CL_SHR, CL_DIV, CL_SHL, CL_MQ, CL_STORE,
		CL_JUMP, CL_JCOND, CL_TAPE_IN, CL_TAPE_OUT, CL_DRUM_IN, CL_DRUM_OUT, CL_SYNC
	} isre_class_e;

	typedef enum logic [4:0] {
		ST_STOP = 5'h01,
		ST_RUN = 5'h02,
		ST_LOAD = 5'h04,
		ST_XFER = 5'h08,
		ST_HALT = 5'h10
	} isre_state_e;

	typedef struct packed {
		logic [WORD_W-1:0] instruction_holding_register;
		logic [WORD_W-1:0] memory_transfer_buffer;
		logic [WORD_W-1:0] quotient_register;
		logic [WORD_W-1:0] quotient_aux_register;
		logic [WORD_W-1:0] accumulator_register;
		logic [WORD_W-1:0] accumulator_aux_register;
	} isre_regs_s;

	typedef struct packed {
		logic start;
		logic stop;
		logic load;
		logic set;
		logic [ADDR_W-1:0] addr;
	} isre_console_s;

	typedef struct packed {
		logic [WORD_W-1:0] acc_res;
		logic [WORD_W-1:0] q_res;
		logic [WORD_W-1:0] operand;
		logic cond_met;
	} isre_exec_s;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} isre_mem_wr_s;

	// Order field to order class
	function automatic isre_class_e op_class(input logic [OP_W-1:0] op);
		case (op)
			OP_ADD, OP_ABS_ADD: op_class = CL_ADD;
			OP_MUL: op_class = CL_MUL;
			OP_DIV: op_class = CL_DIV;
			OP_SHR: op_class = CL_SHR;
			OP_SHL: op_class = CL_SHL;
			OP_MEM_TO_Q: op_class = CL_MQ;
			OP_STORE: op_class = CL_STORE;
			OP_JUMP: op_class = CL_JUMP;
			OP_JUMP_COND: op_class = CL_JCOND;
			OP_TAPE_IN: op_class = CL_TAPE_IN;
			OP_TAPE_OUT: op_class = CL_TAPE_OUT;
			OP_DRUM_IN: op_class = CL_DRUM_IN;
			OP_DRUM_OUT: op_class = CL_DRUM_OUT;
			OP_SYNC_PRINT: op_class = CL_SYNC;
			default: op_class = CL_BAD;
		endcase
	endfunction
endpackage

// [verilog/isre_aux_shift.sv]
// Auxiliary register image: word displaced one place, sign kept
`timescale 1ns/1ps
`default_nettype none
module isre_aux_shift
	import isre_pkg::*;
(
	input wire logic [WORD_W-1:0] word_i, // Source word
	input wire logic left_i, // High: left, low: right
	output logic [WORD_W-1:0] aux_o // Displaced image
);
	// Sign bigit stays, others move one place
	always_comb begin
		if (left_i) begin
			aux_o = {word_i[WORD_W-1], word_i[WORD_W-3:0], 1'b0};
		end else begin
			aux_o = {word_i[WORD_W-1], word_i[WORD_W-1:1]};
		end
	end
endmodule
`default_nettype wire

// [verification/isre_far_model.sv]
// Far side model: main memory that answers fetches and takes stores
`timescale 1ns/1ps
`default_nettype none
module isre_far_model
	import isre_pkg::*;
(
	input wire logic sys_clk_i, // System clock
	input wire logic nrst_i, // Sync reset, low
	input wire logic [3:0] lat_i, // Answer delay in cycles
	input wire logic fetch_req_i, // Sequencer wants a word
	input wire logic [ADDR_W-1:0] addr_i, // Fetch address
	input wire isre_mem_wr_s mem_wr_i, // Store from sequencer
	output logic fetch_o, // Word valid pulse
	output logic [WORD_W-1:0] word_o // Fetched word
);
	logic [WORD_W-1:0] mem [0:4095];
	logic [3:0] wait_q;
	logic fire;
	// Answer once the request has waited long enough
	assign fire = fetch_req_i && !fetch_o && wait_q >= lat_i;
	// Pulse answer; the data line is scrambled outside the answer cycle
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			fetch_o <= 1'b0;
			wait_q <= 4'h0;
			word_o <= WORD_ZERO;
		end else begin
			fetch_o <= fire;
			wait_q <= (fetch_req_i && !fetch_o && !fire) ? wait_q + 4'h1 : 4'h0;
			word_o <= fire ? mem[addr_i] : ~word_o;
		end
	end
	// Stores land in the array; the bench may also preload it
	always @(posedge sys_clk_i) begin
		if (mem_wr_i.valid) begin
			mem[mem_wr_i.addr] <= mem_wr_i.data;
		end
	end
endmodule
`default_nettype wire

// [verification/isre_sequencer_test.sv]
// Testbench of the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module isre_sequencer_test
	import isre_pkg::*;
;
	logic sys_clk_i, nrst_i, fetch_i, exec_i, xfer_valid_i, xfer_end_i;
	logic fetch_req, exec_req, busy, running, halt;
	logic [3:0] lat;
	isre_console_s con;
	isre_exec_s ex;
	isre_regs_s regs;
	isre_mem_wr_s wr;
	logic [WORD_W-1:0] fetch_word_i, xw, sum;
	logic [ADDR_W-1:0] seq;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;

	isre_sequencer uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .console_i(con), .fetch_i(fetch_i),
		.fetch_word_i(fetch_word_i), .exec_i(exec_i), .exec_data_i(ex), .xfer_valid_i(xfer_valid_i),
		.xfer_word_i(xw), .xfer_end_i(xfer_end_i), .seq_counter_o(seq), .regs_o(regs), .mem_wr_o(wr),
		.fetch_req_o(fetch_req), .exec_req_o(exec_req), .xfer_busy_o(busy), .running_o(running),
		.halt_o(halt));
	isre_far_model far (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .lat_i(lat), .fetch_req_i(fetch_req),
		.addr_i(seq), .mem_wr_i(wr), .fetch_o(fetch_i), .word_o(fetch_word_i));

	// Clock and hang limit
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	function automatic logic [WORD_W-1:0] limg(input logic [WORD_W-1:0] w);
		return {w[39], w[37:0], 1'b0};
	endfunction
	function automatic logic [WORD_W-1:0] rimg(input logic [WORD_W-1:0] w);
		return {w[39], w[39:1]};
	endfunction
	function automatic logic [WORD_W-1:0] ord(input logic [OP_W-1:0] op, input logic [11:0] m, a);
		return {8'h00, m, op, a};
	endfunction

	task automatic chk_w(input string what, input logic [WORD_W-1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_a(input string what, input logic [ADDR_W-1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_b(input string what, input logic exp, got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic do_reset();
		nrst_i = 1'b0;
		tick(20);
		nrst_i = 1'b1;
		tick(1);
	endtask
	// Console button: 0 start, 1 stop, 2 load, 3 set
	task automatic press(input int which, input logic [ADDR_W-1:0] a);
		con.addr = a;
		con[15-which] = 1'b1;
		tick(8);
		con[15-which] = 1'b0;
		tick(8);
	endtask
	task automatic wait_exec();
		for (int i = 0; i < 50 && exec_req !== 1'b1; i++)
			tick(1);
		chk_b("exec request", 1'b1, exec_req);
	endtask
	task automatic do_exec(input logic [WORD_W-1:0] a, q, op, input logic c);
		wait_exec();
		ex = '{a, q, op, c};
		exec_i = 1'b1;
		tick(1);
		exec_i = 1'b0;
		tick(1);
	endtask

	// Reset state
	task automatic t_reset();
		chk_a("reset counter", ADDR_RST, seq);
		chk_w("reset acc", WORD_ZERO, regs.accumulator_register);
	endtask

	// Program run: steps, orders, transfers, drum, tape, bad order
	task automatic t_run();
		far.mem[12'h010] = ord(OP_ADD, 12'h000, 12'h000);
		far.mem[12'h011] = ord(OP_SHL, 12'h000, 12'h000);
		far.mem[12'h012] = ord(OP_JUMP, 12'h000, 12'h030);
		far.mem[12'h030] = ord(OP_SYNC_PRINT, 12'h000, 12'h000);
		far.mem[12'h031] = ord(OP_JUMP_COND, 12'h000, 12'h070);
		far.mem[12'h032] = ord(OP_JUMP_COND, 12'h000, 12'h040);
		far.mem[12'h040] = ord(OP_DRUM_IN, 12'h420, 12'h050);
		far.mem[12'h050] = ord(OP_TAPE_OUT, 12'h000, 12'h000);
		far.mem[12'h051] = ord(OP_MUL, 12'h000, 12'h000);
		far.mem[12'h052] = ord(OP_DIV, 12'h000, 12'h000);
		far.mem[12'h053] = ord(OP_SHR, 12'h000, 12'h000);
		far.mem[12'h054] = ord(OP_ABS_ADD, 12'h000, 12'h000);
		far.mem[12'h055] = ord(OP_STORE, 12'h000, 12'h300);
		far.mem[12'h056] = ord(OP_MEM_TO_Q, 12'h000, 12'h000);
		far.mem[12'h057] = ord(OP_DRUM_OUT, 12'h180, 12'h058);
		far.mem[12'h058] = ord(OP_TAPE_IN, 12'h000, 12'h000);
		press(3, 12'h010);
		chk_a("set counter", 12'h010, seq);
		press(0, 12'h000);
		wait_exec();
		chk_a("step", 12'h011, seq);
		chk_w("holding", far.mem[12'h010], regs.instruction_holding_register);
		do_exec(40'h12_3456_789a, WORD_ZERO, 40'h55, 1'b0);
		chk_w("add aux", limg(40'h12_3456_789a), regs.accumulator_aux_register);
		do_exec(40'h81_0000_0003, 40'h7, WORD_ZERO, 1'b0);
		chk_w("shl aux", rimg(40'h81_0000_0003), regs.accumulator_aux_register);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		wait_exec();
		chk_a("jump", 12'h031, seq);
		lat = 4'h0;
		do_exec(40'h3, WORD_ZERO, WORD_ZERO, 1'b0);
		chk_w("sync acc", WORD_ONES, regs.accumulator_register);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		wait_exec();
		chk_a("cond not met", 12'h033, seq);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b1);
		wait_exec();
		chk_a("cond met", 12'h041, seq);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		chk_a("drum start", 12'h100, seq);
		sum = WORD_ZERO;
		xfer_valid_i = 1'b1;
		for (int k = 1; k <= 50; k++) begin
			xw = 40'(k) * 40'h0f_0000_0011;
			sum = sum + xw;
			tick(1);
			chk_a("drum store", 12'h0ff + 12'(k), wr.addr);
			if (k < 50)
				chk_a("drum walk", 12'h100 + 12'(k), seq);
		end
		xfer_valid_i = 1'b0;
		chk_a("drum end", 12'h050, seq);
		chk_b("fetch request", 1'b1, fetch_req);
		chk_w("drum sum", sum, regs.accumulator_register);
		chk_w("drum q", xw, regs.quotient_register);
		chk_w("drum buffer", xw, regs.memory_transfer_buffer);
		chk_w("drum q aux", rimg(xw), regs.quotient_aux_register);
		xw = ~xw;
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		xfer_valid_i = 1'b1;
		xw = 40'ha1;
		tick(1);
		xw = 40'hb2;
		tick(1);
		xfer_valid_i = 1'b0;
		xw = ~xw;
		xfer_end_i = 1'b1;
		tick(1);
		xfer_end_i = 1'b0;
		tick(1);
		chk_w("tape out buffer", 40'hb2, regs.memory_transfer_buffer);
		do_exec(40'h40_0000_0001, 40'h0c, 40'h66, 1'b0);
		chk_w("mul aux", limg(40'h40_0000_0001), regs.accumulator_aux_register);
		do_exec(40'hc0_0000_0005, 40'h09, 40'h33, 1'b0);
		chk_w("div aux", rimg(40'hc0_0000_0005), regs.accumulator_aux_register);
		do_exec(40'h20_0000_0100, 40'h01, WORD_ZERO, 1'b0);
		chk_w("shr aux", limg(40'h20_0000_0100), regs.accumulator_aux_register);
		do_exec(40'h05_0000_0007, WORD_ZERO, 40'h77, 1'b0);
		chk_w("abs add aux", limg(40'h05_0000_0007), regs.accumulator_aux_register);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		do_exec(WORD_ZERO, WORD_ZERO, 40'h44, 1'b0);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		chk_a("drum out start", 12'h180, seq);
		xfer_valid_i = 1'b1;
		for (int k = 1; k <= 50; k++) begin
			xw = 40'(k);
			tick(1);
		end
		xfer_valid_i = 1'b0;
		chk_a("drum out end", 12'h058, seq);
		chk_w("drum out buffer", 40'h32, regs.memory_transfer_buffer);
		do_exec(WORD_ZERO, WORD_ZERO, WORD_ZERO, 1'b0);
		xfer_valid_i = 1'b1;
		xw = 40'hc3;
		tick(1);
		xw = 40'hd4;
		tick(1);
		xfer_valid_i = 1'b0;
		xfer_end_i = 1'b1;
		tick(1);
		xfer_end_i = 1'b0;
		chk_w("tape q", 40'hd4, regs.quotient_register);
		chk_w("tape buffer", 40'hd4, regs.memory_transfer_buffer);
		chk_w("tape q aux", rimg(40'hd4), regs.quotient_aux_register);
		for (int i = 0; i < 50 && halt !== 1'b1; i++)
			tick(1);
		chk_b("halt", 1'b1, halt);
		chk_a("bad order place", 12'h059, seq - 12'h001);
		press(1, 12'h000);
		chk_b("stopped", 1'b0, running);
		chk_b("halt cleared", 1'b0, halt);
	endtask

	// Load from tape
	task automatic t_load();
		sum = WORD_ZERO;
		press(3, 12'h200);
		press(2, 12'h000);
		chk_b("loading", 1'b1, busy);
		xfer_valid_i = 1'b1;
		for (int k = 0; k < 4; k++) begin
			xw = 40'h80_0000_0001 + 40'(k) * 40'h11_1111_1111;
			sum = sum + xw;
			tick(1);
			chk_a("load store", 12'h200 + 12'(k), wr.addr);
			chk_w("load data", xw, wr.data);
			chk_w("load holding", WORD_ZERO, regs.instruction_holding_register);
			chk_w("load aux", limg(sum), regs.accumulator_aux_register);
		end
		xfer_valid_i = 1'b0;
		xw = ~xw;
		xfer_end_i = 1'b1;
		tick(1);
		xfer_end_i = 1'b0;
		tick(1);
		chk_a("load end", 12'h200, seq);
		chk_w("load sum", sum, regs.accumulator_register);
		chk_w("load memory", 40'hb3_3333_3334, far.mem[12'h203]);
	endtask

	task automatic end_of_test();
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		con = '0;
		ex = '0;
		exec_i = 1'b0;
		xfer_valid_i = 1'b0;
		xfer_end_i = 1'b0;
		xw = WORD_ZERO;
		lat = 4'h3;
		nrst_i = 1'b0;
		do_reset();
		t_reset();
		t_run();
		do_reset();
		t_load();
		end_of_test();
	end
endmodule
`default_nettype wire
